// ==== src/bmc_cmd.sv ====
// Memory command interpreter with its transmit FIFO
`timescale 1ns/1ns
module bmc_fifo #(
  parameter int W = 8,
  parameter int D = bmc_pkg::FIFO_DEPTH
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] store [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;
  logic          outv_reg;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign push      = in_valid && in_ready && !flush;
  assign pop       = outv_reg && out_ready && !flush;
  assign out_valid = outv_reg;

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_reg] <= in_data;
    end
  end

  // Head word is held in a register so the output never glitches
  always_ff @(posedge clock) begin
    if (reset || flush) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      outv_reg <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      // Count includes the head, so a pop refills only from a second word
      if ((!outv_reg && cnt_reg != '0)
          || (pop && cnt_reg > (AW+1)'(1))) begin
        out_data <= store[rd_reg];
        rd_reg   <= rd_reg + 1'b1;
        outv_reg <= 1'b1;
      end else if (pop) begin
        outv_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module bmc_cmd #(
  parameter int TEMP_MAX_CYC = bmc_pkg::TEMP_MAX_CYC,
  parameter int VOLT_MAX_CYC = bmc_pkg::VOLT_MAX_CYC,
  parameter int NV_WRITE_CYC = bmc_pkg::NV_MAX_CYC
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        bus_reset,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_byte,
  output logic             poll_active,
  output logic             poll_bit,
  output logic             temp_start,
  input  wire logic        temp_done,
  input  wire logic [15:0] temp_result,
  output logic             volt_start,
  input  wire logic        volt_done,
  input  wire logic [15:0] volt_result,
  output logic             volt_source,
  output logic             nonvolatile_busy_flag,
  output logic             temperature_busy_flag,
  output logic             converter_busy_flag,
  output logic             integrated_current_accum,
  output logic             charge_accum_enable,
  output logic             accum_shadow_enable
);
  localparam int CW = bmc_pkg::CNT_W;
  bmc_pkg::bmc_state_t state_reg, state_next;
  logic [7:0]  scratch_buffer [bmc_pkg::PAGES][bmc_pkg::PAGE_BYTES];
  logic [7:0]  store_mem [bmc_pkg::PAGES][bmc_pkg::PAGE_BYTES];
  logic [7:0]  cmd_reg;
  logic [2:0]  page_reg;
  logic [3:0]  idx_reg;
  logic [7:0]  crc_reg;
  logic [3:0]  cfg_reg;
  logic [2:0]  poll_reg;
  logic        temp_busy_reg, conv_busy_reg, nv_busy_reg;
  logic [CW-1:0] temp_cnt_reg, volt_cnt_reg, nv_cnt_reg;
  logic        temp_start_reg, volt_start_reg;
  logic        page_take, copy_go, recall_go, conv_t_go, conv_v_go;
  logic        temp_fin, volt_fin, nv_fin, wr_take, rd_push, rd_ready;
  logic [7:0]  rd_byte, status_byte;

  function automatic logic [7:0] bmc_crc8(input logic [7:0] crc,
                                          input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ bmc_pkg::CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

  assign page_take = (state_reg == bmc_pkg::ST_PAGE) && rx_valid
                     && rx_byte <= bmc_pkg::PAGE_MAX;
  assign copy_go   = page_take && cmd_reg == bmc_pkg::CMD_COPY_SCR;
  assign recall_go = page_take && cmd_reg == bmc_pkg::CMD_RECALL;
  assign conv_t_go = (state_reg == bmc_pkg::ST_CMD) && rx_valid
                     && rx_byte == bmc_pkg::CMD_CONV_TEMP;
  assign conv_v_go = (state_reg == bmc_pkg::ST_CMD) && rx_valid
                     && rx_byte == bmc_pkg::CMD_CONV_VOLT;
  assign wr_take   = (state_reg == bmc_pkg::ST_WRITE) && rx_valid
                     && !idx_reg[3];
  assign rd_push   = (state_reg == bmc_pkg::ST_READ) && rd_ready && !bus_reset;
  assign temp_fin  = temp_busy_reg
                     && (temp_done || temp_cnt_reg == CW'(TEMP_MAX_CYC - 1));
  assign volt_fin  = conv_busy_reg
                     && (volt_done || volt_cnt_reg == CW'(VOLT_MAX_CYC - 1));
  assign nv_fin    = nv_busy_reg && nv_cnt_reg == CW'(NV_WRITE_CYC - 1);
  assign status_byte = {1'b1, conv_busy_reg, nv_busy_reg, temp_busy_reg,
                        cfg_reg};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bmc_pkg::ST_CMD: begin
        if (rx_valid) begin
          case (rx_byte)
            bmc_pkg::CMD_READ_SCR, bmc_pkg::CMD_WRITE_SCR,
            bmc_pkg::CMD_COPY_SCR, bmc_pkg::CMD_RECALL: begin
              state_next = bmc_pkg::ST_PAGE;
            end
            bmc_pkg::CMD_CONV_TEMP, bmc_pkg::CMD_CONV_VOLT: begin
              state_next = bmc_pkg::ST_POLL;
            end
            default: begin
              state_next = bmc_pkg::ST_IGNORE;
            end
          endcase
        end
      end
      bmc_pkg::ST_PAGE: begin
        if (rx_valid && rx_byte > bmc_pkg::PAGE_MAX) begin
          state_next = bmc_pkg::ST_IGNORE;
        end else if (rx_valid) begin
          case (cmd_reg)
            bmc_pkg::CMD_READ_SCR:  state_next = bmc_pkg::ST_READ;
            bmc_pkg::CMD_WRITE_SCR: state_next = bmc_pkg::ST_WRITE;
            bmc_pkg::CMD_COPY_SCR:  state_next = bmc_pkg::ST_POLL;
            default:                state_next = bmc_pkg::ST_IDLE;
          endcase
        end
      end
      bmc_pkg::ST_WRITE, bmc_pkg::ST_READ, bmc_pkg::ST_POLL,
      bmc_pkg::ST_IGNORE, bmc_pkg::ST_IDLE: begin
        state_next = state_reg;
      end
      default: begin
        state_next = bmc_pkg::ST_CMD;
      end
    endcase
    if (bus_reset) begin
      state_next = bmc_pkg::ST_CMD;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= bmc_pkg::ST_CMD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_reg  <= '0;
      page_reg <= '0;
      poll_reg <= '0;
    end else begin
      if (state_reg == bmc_pkg::ST_CMD && rx_valid) begin
        cmd_reg <= rx_byte;
      end
      if (page_take) begin
        page_reg <= rx_byte[2:0];
      end
      if (bus_reset) begin
        poll_reg <= '0;
      end else if (conv_t_go) begin
        poll_reg <= 3'b001;
      end else if (copy_go) begin
        poll_reg <= 3'b010;
      end else if (conv_v_go) begin
        poll_reg <= 3'b100;
      end
    end
  end

  // Read stream: page data, CRC, then fill forever until bus reset
  always_comb begin
    if (!idx_reg[3]) begin
      rd_byte = scratch_buffer[page_reg][idx_reg[2:0]];
      if (page_reg == 3'h0 && idx_reg[2:0] == 3'h0) begin
        rd_byte = rd_byte | bmc_pkg::RSV_MASK;
      end
    end else if (idx_reg == bmc_pkg::CRC_IDX) begin
      rd_byte = crc_reg;
    end else begin
      rd_byte = bmc_pkg::FILL_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || page_take) begin
      idx_reg <= '0;
      crc_reg <= '0;
    end else if (rd_push || wr_take) begin
      if (idx_reg <= bmc_pkg::CRC_IDX) begin
        idx_reg <= idx_reg + 4'h1;
      end
      if (rd_push && !idx_reg[3]) begin
        crc_reg <= bmc_crc8(crc_reg, rd_byte);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (wr_take) begin
      scratch_buffer[page_reg][idx_reg[2:0]] <= rx_byte;
    end else if (recall_go) begin
      scratch_buffer[rx_byte[2:0]] <= store_mem[rx_byte[2:0]];
      if (rx_byte[2:0] == 3'h0) begin
        scratch_buffer[0][0] <= status_byte;
      end
    end
  end

  // Live config byte; writes take effect at once, not only after a copy
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_reg <= '0;
    end else if (wr_take && page_reg == 3'h0 && idx_reg == 4'h0) begin
      cfg_reg <= rx_byte[3:0];
    end else if (copy_go && rx_byte[2:0] == 3'h0) begin
      cfg_reg <= scratch_buffer[0][0][3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (copy_go) begin
      store_mem[rx_byte[2:0]] <= scratch_buffer[rx_byte[2:0]];
    end
    if (temp_fin) begin
      store_mem[0][bmc_pkg::TEMP_LSB_ADDR] <= temp_result[7:0];
      store_mem[0][bmc_pkg::TEMP_MSB_ADDR] <= temp_result[15:8];
    end
    if (volt_fin) begin
      store_mem[0][bmc_pkg::VOLT_LSB_ADDR] <= volt_result[7:0];
      store_mem[0][bmc_pkg::VOLT_MSB_ADDR] <= volt_result[15:8];
    end
  end

  // Busy timers force completion so a stuck converter cannot hang polling
  always_ff @(posedge clock) begin
    if (reset) begin
      temp_busy_reg <= 1'b0;
      temp_cnt_reg  <= '0;
    end else if (conv_t_go && !temp_busy_reg) begin
      temp_busy_reg <= 1'b1;
      temp_cnt_reg  <= '0;
    end else if (temp_fin) begin
      temp_busy_reg <= 1'b0;
    end else if (temp_busy_reg) begin
      temp_cnt_reg <= temp_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      conv_busy_reg <= 1'b0;
      volt_cnt_reg  <= '0;
    end else if (conv_v_go && !conv_busy_reg) begin
      conv_busy_reg <= 1'b1;
      volt_cnt_reg  <= '0;
    end else if (volt_fin) begin
      conv_busy_reg <= 1'b0;
    end else if (conv_busy_reg) begin
      volt_cnt_reg <= volt_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      nv_busy_reg <= 1'b0;
      nv_cnt_reg  <= '0;
    end else if (copy_go) begin
      nv_busy_reg <= 1'b1;
      nv_cnt_reg  <= '0;
    end else if (nv_fin) begin
      nv_busy_reg <= 1'b0;
    end else if (nv_busy_reg) begin
      nv_cnt_reg <= nv_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      temp_start_reg <= 1'b0;
      volt_start_reg <= 1'b0;
    end else begin
      temp_start_reg <= conv_t_go && !temp_busy_reg;
      volt_start_reg <= conv_v_go && !conv_busy_reg;
    end
  end

  // Whole bytes cross here; slot layer shifts them LSB first
  bmc_fifo #(.W(8), .D(bmc_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clock     (clock),
    .reset     (reset),
    .flush     (bus_reset),
    .in_valid  (rd_push),
    .in_ready  (rd_ready),
    .in_data   (rd_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_byte)
  );

  assign poll_active = (state_reg == bmc_pkg::ST_POLL);
  assign poll_bit = ~|(poll_reg & {conv_busy_reg, nv_busy_reg, temp_busy_reg});
  assign temp_start               = temp_start_reg;
  assign volt_start               = volt_start_reg;
  assign volt_source              = cfg_reg[bmc_pkg::CFG_AD_BIT];
  assign integrated_current_accum = cfg_reg[bmc_pkg::CFG_CURR_BIT];
  assign charge_accum_enable      = cfg_reg[bmc_pkg::CFG_CHG_BIT];
  assign accum_shadow_enable      = cfg_reg[bmc_pkg::CFG_SHADOW_BIT];
  assign nonvolatile_busy_flag    = nv_busy_reg;
  assign temperature_busy_flag    = temp_busy_reg;
  assign converter_busy_flag      = conv_busy_reg;

  sequence s_copy_cmd;
    copy_go;
  endsequence

  sequence s_volt_busy_after_go;
    conv_v_go ##1 (poll_active && conv_busy_reg);
  endsequence

  chk_copy_sets_busy: assert property (
    @(posedge clock) disable iff (reset)
    s_copy_cmd |=> nv_busy_reg && poll_active)
    else $error("copy did not raise nonvolatile busy");
  chk_copy_poll_bit: assert property (
    @(posedge clock) disable iff (reset)
    poll_active && poll_reg == 3'b010 |-> poll_bit == !nv_busy_reg)
    else $error("copy poll answer wrong");
  chk_temp_poll_bit: assert property (
    @(posedge clock) disable iff (reset)
    poll_active && poll_reg == 3'b001 |-> poll_bit != temp_busy_reg)
    else $error("temperature poll answer wrong");
  chk_volt_poll_bit: assert property (
    @(posedge clock) disable iff (reset)
    s_volt_busy_after_go |-> !poll_bit)
    else $error("voltage poll answered done while busy");
  chk_temp_start_busy: assert property (
    @(posedge clock) disable iff (reset)
    conv_t_go && !temp_busy_reg |=> temp_busy_reg && temp_start)
    else $error("temperature conversion did not start");
  chk_temp_time_bound: assert property (
    @(posedge clock) disable iff (reset)
    temp_busy_reg |-> temp_cnt_reg < CW'(TEMP_MAX_CYC))
    else $error("temperature conversion overran");
  chk_volt_time_bound: assert property (
    @(posedge clock) disable iff (reset)
    conv_busy_reg |-> volt_cnt_reg < CW'(VOLT_MAX_CYC))
    else $error("voltage conversion overran");
  chk_nv_time_bound: assert property (
    @(posedge clock) disable iff (reset)
    nv_busy_reg |-> nv_cnt_reg < CW'(NV_WRITE_CYC))
    else $error("memory write overran");
  chk_volt_result_store: assert property (
    @(posedge clock) disable iff (reset)
    volt_fin |=> !conv_busy_reg
      && store_mem[0][bmc_pkg::VOLT_LSB_ADDR] == $past(volt_result[7:0]))
    else $error("voltage result not stored");
  chk_reset_abandon: assert property (
    @(posedge clock) disable iff (reset)
    bus_reset |=> state_reg == bmc_pkg::ST_CMD && !tx_valid)
    else $error("read not abandoned on bus reset");
  chk_bad_page_ignore: assert property (
    @(posedge clock) disable iff (reset)
    state_reg == bmc_pkg::ST_PAGE && rx_valid && !bus_reset
      && rx_byte > bmc_pkg::PAGE_MAX
    |=> state_reg == bmc_pkg::ST_IGNORE)
    else $error("bad page not ignored");
  chk_fill_after_crc: assert property (
    @(posedge clock) disable iff (reset)
    rd_push && idx_reg > bmc_pkg::CRC_IDX
    |-> rd_byte == bmc_pkg::FILL_BYTE)
    else $error("bytes after CRC not all ones");
  chk_cmd_during_volt: assert property (
    @(posedge clock) disable iff (reset)
    conv_busy_reg && copy_go |=> nv_busy_reg)
    else $error("copy blocked by voltage conversion");
endmodule

// ==== pkg/bmc_pkg.sv ====
// Constants and types for the battery monitor memory command handler
package bmc_pkg;
  localparam logic [7:0] CMD_READ_SCR   = 8'hbe;
  localparam logic [7:0] CMD_WRITE_SCR  = 8'h4e;
  localparam logic [7:0] CMD_COPY_SCR   = 8'h48;
  localparam logic [7:0] CMD_RECALL     = 8'hb8;
  localparam logic [7:0] CMD_CONV_TEMP  = 8'h44;
  localparam logic [7:0] CMD_CONV_VOLT  = 8'hb4;
  localparam logic [7:0] PAGE_MAX       = 8'h07;
  localparam logic [7:0] FILL_BYTE      = 8'hff;
  localparam logic [7:0] CRC_POLY_REFL  = 8'h8c;
  localparam logic [7:0] RSV_MASK       = 8'h80;
  localparam int         PAGES          = 8;
  localparam int         PAGE_BYTES     = 8;
  localparam logic [3:0] CRC_IDX        = 4'h8;
  localparam int         CFG_CURR_BIT   = 0;
  localparam int         CFG_CHG_BIT    = 1;
  localparam int         CFG_SHADOW_BIT = 2;
  localparam int         CFG_AD_BIT     = 3;
  localparam logic [2:0] TEMP_LSB_ADDR  = 3'h1;
  localparam logic [2:0] TEMP_MSB_ADDR  = 3'h2;
  localparam logic [2:0] VOLT_LSB_ADDR  = 3'h3;
  localparam logic [2:0] VOLT_MSB_ADDR  = 3'h4;
  localparam int         FIFO_DEPTH     = 32;
  localparam int         CLK_MHZ        = 125;
  localparam int         TEMP_MAX_US    = 10000;
  localparam int         VOLT_MAX_US    = 4000;
  localparam int         NV_MAX_US      = 10000;
  localparam int         TEMP_MAX_CYC   = TEMP_MAX_US * CLK_MHZ;
  localparam int         VOLT_MAX_CYC   = VOLT_MAX_US * CLK_MHZ;
  localparam int         NV_MAX_CYC     = NV_MAX_US * CLK_MHZ;
  localparam int         CNT_W          = 24;
  typedef enum logic [6:0] {
    ST_CMD    = 7'b0000001,
    ST_PAGE   = 7'b0000010,
    ST_WRITE  = 7'b0000100,
    ST_READ   = 7'b0001000,
    ST_POLL   = 7'b0010000,
    ST_IGNORE = 7'b0100000,
    ST_IDLE   = 7'b1000000
  } bmc_state_t;
endpackage

// ==== verification/bmc_master_model.sv ====
// Byte-level bus master model facing the memory command handler
`timescale 1ns/1ns
module bmc_master_model (
  input  wire logic       clock,
  output logic            bus_reset,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_byte
);
  initial begin
    bus_reset = 1'b0;
    rx_valid  = 1'b0;
    rx_byte   = 8'h00;
    tx_ready  = 1'b0;
  end
  // Reset pulse and presence; the ROM layer eats the skip byte upstream
  task automatic init_seq();
    @(negedge clock);
    bus_reset = 1'b1;
    tx_ready  = 1'b0;
    @(negedge clock);
    bus_reset = 1'b0;
  endtask
  // Bit order lives in the slot layer, so whole bytes cross here
  task automatic send_byte(input logic [7:0] b);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_byte  = b;
    @(negedge clock);
    rx_valid = 1'b0;
    rx_byte  = ~b; // Released data must not look like a fresh byte
  endtask
  task automatic get_byte(input int stall, output logic [7:0] b,
                          output logic ok);
    ok = 1'b0;
    b  = 8'h00;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clock);
      tx_ready = (i >= stall) && (tx_valid === 1'b1);
      if (tx_ready) begin
        b  = tx_byte;
        ok = 1'b1;
      end
    end
    // Drop ready once the pop edge has passed, so no byte is lost unseen
    if (ok) begin
      @(negedge clock);
      tx_ready = 1'b0;
    end
  endtask
endmodule

// ==== verification/bmc_cmd_tb.sv ====
// Self-checking bench for the memory command handler
`timescale 1ns/1ns
module bmc_cmd_tb;
  localparam int T_CYC = 50;
  localparam int V_CYC = 60;
  localparam int N_CYC = 40;
  logic        clock       = 1'b0;
  logic        reset       = 1'b1;
  logic        temp_done   = 1'b0;
  logic        volt_done   = 1'b0;
  logic [15:0] temp_result = 16'h1234;
  logic [15:0] volt_result = 16'h0abc;
  logic        bus_reset, rx_valid, tx_valid, tx_ready;
  logic        poll_active, poll_bit, temp_start, volt_start, volt_source;
  logic        nonvolatile_busy_flag, temperature_busy_flag;
  logic        converter_busy_flag, integrated_current_accum;
  logic        charge_accum_enable, accum_shadow_enable;
  logic [7:0]  rx_byte, tx_byte;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          cycle_count = 0;
  int          t0;

  always #4 clock = ~clock;

  bmc_cmd #(.TEMP_MAX_CYC(T_CYC), .VOLT_MAX_CYC(V_CYC),
            .NV_WRITE_CYC(N_CYC)) uut (
    .clock(clock), .reset(reset), .bus_reset(bus_reset),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .poll_active(poll_active),
    .poll_bit(poll_bit), .temp_start(temp_start), .temp_done(temp_done),
    .temp_result(temp_result), .volt_start(volt_start),
    .volt_done(volt_done), .volt_result(volt_result),
    .volt_source(volt_source),
    .nonvolatile_busy_flag(nonvolatile_busy_flag),
    .temperature_busy_flag(temperature_busy_flag),
    .converter_busy_flag(converter_busy_flag),
    .integrated_current_accum(integrated_current_accum),
    .charge_accum_enable(charge_accum_enable),
    .accum_shadow_enable(accum_shadow_enable)
  );

  bmc_master_model host (
    .clock(clock), .bus_reset(bus_reset), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte)
  );

  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count >= 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? bmc_pkg::CRC_POLY_REFL : 8'h00);
    return r;
  endfunction

  function automatic logic flag_of(input int which);
    case (which)
      0: return nonvolatile_busy_flag;
      1: return temperature_busy_flag;
      default: return converter_busy_flag;
    endcase
  endfunction

  task automatic wait_low(input int which, input int lim);
    for (int n = 0; n < lim && flag_of(which) !== 1'b0; n++)
      @(negedge clock);
  endtask

  // Negative page means a command without a page byte
  task automatic command(input logic [7:0] c, input int page);
    host.init_seq();
    host.send_byte(c);
    if (page >= 0) host.send_byte(page[7:0]);
  endtask

  task automatic write_page(input int page, input int n,
                            input logic [7:0] base);
    command(bmc_pkg::CMD_WRITE_SCR, page);
    for (int i = 0; i < n; i++) host.send_byte(base + i[7:0]);
  endtask

  task automatic read_page(input int page, input int cnt,
                           output logic [7:0] q[10]);
    logic ok;
    command(bmc_pkg::CMD_READ_SCR, page);
    for (int i = 0; i < cnt; i++) begin
      host.get_byte(i % 3, q[i], ok);
      check(ok, 1'b1);
    end
  endtask

  initial begin
    logic [7:0] q[10];
    logic [7:0] crc;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check({poll_bit, tx_valid, nonvolatile_busy_flag}, 3'b100);
    // Top page, full stream with stalls
    write_page(7, 8, 8'h30);
    read_page(7, 10, q);
    crc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      check(q[i], 8'h30 + i[7:0]);
      crc = crc8(crc, 8'h30 + i[7:0]);
    end
    check(q[8], crc);
    check(q[9], bmc_pkg::FILL_BYTE);
    read_page(7, 2, q);
    host.init_seq();
    @(negedge clock);
    check(tx_valid, 1'b0);
    write_page(0, 1, 8'h0f);
    @(negedge clock);
    check({integrated_current_accum, charge_accum_enable,
           accum_shadow_enable, volt_source}, 4'hf);
    command(bmc_pkg::CMD_COPY_SCR, 7);
    t0 = cycle_count;
    @(negedge clock);
    check({nonvolatile_busy_flag, poll_active, poll_bit},
          3'b110);
    wait_low(0, N_CYC + 4);
    check(cycle_count - t0 <= N_CYC + 1, 1'b1);
    check({nonvolatile_busy_flag, poll_bit}, 2'b01);
    // Scratchpad overwritten, so only a real recall brings back the copy
    write_page(7, 8, 8'ha0);
    command(bmc_pkg::CMD_RECALL, 7);
    read_page(7, 8, q);
    for (int i = 0; i < 8; i++)
      check(q[i], 8'h30 + i[7:0]);
    // Start pulse lasts one cycle, so look right after the command byte
    command(bmc_pkg::CMD_CONV_TEMP, -1);
    check({temp_start, temperature_busy_flag, poll_bit},
          3'b110);
    repeat (4) @(negedge clock);
    temp_done = 1'b1;
    @(negedge clock);
    temp_done = 1'b0;
    @(negedge clock);
    check({temperature_busy_flag, poll_bit}, 2'b01);
    command(bmc_pkg::CMD_CONV_TEMP, -1);
    t0 = cycle_count;
    wait_low(1, T_CYC + 4);
    check(cycle_count - t0 <= T_CYC + 1, 1'b1);
    command(bmc_pkg::CMD_CONV_VOLT, -1);
    t0 = cycle_count;
    check({volt_start, converter_busy_flag, poll_bit},
          3'b110);
    write_page(5, 1, 8'h5a);
    read_page(5, 1, q);
    check({q[0], converter_busy_flag}, {8'h5a, 1'b1});
    wait_low(2, V_CYC + 4);
    check(cycle_count - t0 <= V_CYC + 1, 1'b1);
    command(bmc_pkg::CMD_RECALL, 0);
    read_page(0, 5, q);
    check(q[0], 8'h8f);
    check({q[2], q[1]}, temp_result);
    check({q[4], q[3]}, volt_result);
    // Out-of-range page must also swallow the bytes behind it
    command(bmc_pkg::CMD_READ_SCR, 8);
    host.send_byte(bmc_pkg::CMD_CONV_TEMP);
    repeat (3) @(negedge clock);
    check({tx_valid, temp_start, temperature_busy_flag}, 3'b000);
    complete_run();
  end
endmodule
